// ### common/cmp_ctl_pkg.sv
// shared constants and types for the comparator control and interrupt block
package cmp_ctl_pkg;

    // ------------------------------------------------------------------
    // register map (byte addresses)
    // ------------------------------------------------------------------
    localparam logic [7:0] ADDR_CTL_ONE = 8'h59;
    localparam logic [7:0] ADDR_CTL_TWO = 8'h5a;
    localparam logic [7:0] ADDR_PBD = 8'h5b;

    localparam logic [7:0] RST_CTL_ONE = 8'h00;
    localparam logic [7:0] RST_CTL_TWO = 8'h00;
    localparam logic [7:0] RST_PBD = 8'h00;

    // ------------------------------------------------------------------
    // control one fields
    // ------------------------------------------------------------------
    localparam int BIT_EXCHANGE = 7;
    localparam int BIT_REF_TERM = 6;
    localparam int BIT_REF_LVL_HI = 5;
    localparam int BIT_REF_LVL_LO = 4;
    localparam int BIT_POWER_ON = 3;
    localparam int BIT_EDGE_POL = 2;
    localparam int BIT_IRQ_EN = 1;
    localparam int BIT_EVT_FLAG = 0;

    // ------------------------------------------------------------------
    // control two fields
    // ------------------------------------------------------------------
    localparam int BIT_SHORT = 7;
    localparam int BIT_MUX_HI = 6;
    localparam int BIT_MUX_LO = 2;
    localparam int BIT_FILTER = 1;
    localparam int BIT_RAW_OUT = 0;

    localparam int MUX_W = 5;
    localparam int PIN_COUNT = 8;

    // reference level choices
    typedef enum logic [1:0] {
        REF_OFF,
        REF_QUARTER,
        REF_HALF,
        REF_THRESHOLD
    } ref_level_e;

endpackage : cmp_ctl_pkg

// ### core/cmp_sync_edge.sv
// two-stage synchroniser with edge detection on the second stage
module cmp_sync_edge (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic async_i,
    input wire logic falling_i,
    output logic level_o,
    output logic edge_o
);
    typedef struct packed {
        logic meta;
        logic sync;
        logic last;
    } sync_s;

    sync_s state;
    sync_s next_state;

    always_comb begin
        next_state = state;
        next_state.meta = async_i;
        next_state.sync = state.meta;
        next_state.last = state.sync;
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end

    assign level_o = state.sync;
    // chosen edge of the synchronised level; first stage is read by sync only
    assign edge_o = falling_i ? (state.last & ~state.sync) : (~state.last & state.sync);
endmodule : cmp_sync_edge

// ### core/cmp_pin_map.sv
// decodes the input multiplexer selection into per-pin buffer disables
module cmp_pin_map #(
    parameter int PINS = cmp_ctl_pkg::PIN_COUNT
) (
    input wire logic [cmp_ctl_pkg::MUX_W-1:0] mux_sel_i,
    input wire logic [PINS-1:0] pbd_i,
    output logic [PINS-1:0] disable_o
);
    import cmp_ctl_pkg::*;

    // each multiplexer select bit connects the pin of the same index
    function automatic logic [PINS-1:0] mux_pins(input logic [MUX_W-1:0] sel);
        logic [PINS-1:0] p;
        p = '0;
        for (int i = 0; i < MUX_W && i < PINS; i++) begin
            p[i] = sel[i];
        end
        return p;
    endfunction : mux_pins

    assign disable_o = pbd_i | mux_pins(mux_sel_i);
endmodule : cmp_pin_map

// ### core/cmp_ctl_top.sv
// comparator control registers, analog core controls and interrupt logic
// ----------------------------------------------------------------------
// ----------------------------------------------------------------------
//
// Decided for this implementation: the strobed register port.
module cmp_ctl_top #(
    parameter int PINS = cmp_ctl_pkg::PIN_COUNT
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    // register port
    input wire logic [7:0] addr_i,
    input wire logic [7:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [7:0] rdata_o,
    // analog core
    input wire logic cmp_raw_i,
    input wire logic cmp_filtered_i,
    output logic input_short_ctl_o,
    output logic output_filter_en_o,
    output cmp_ctl_pkg::ref_level_e ref_level_sel_o,
    output logic ref_terminal_sel_o,
    output logic input_exchange_o,
    output logic cmp_power_on_o,
    output logic [cmp_ctl_pkg::MUX_W-1:0] input_mux_sel_o,
    output logic cmp_output_o,
    // port buffers
    output logic [PINS-1:0] pin_buffer_disable_o,
    // interrupt
    input wire logic global_irq_en_i,
    input wire logic irq_ack_i,
    output logic irq_o
);
    import cmp_ctl_pkg::*;

    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [7:0] ctl_one;
        logic [7:0] ctl_two;
        logic [PINS-1:0] pbd;
        logic [PINS-1:0] pin_dis;
        logic [7:0] rdata;
        logic irq;
        logic cmp_out;
    } top_s;

    top_s state;
    top_s next_state;

    logic sel_out;
    logic presented;
    logic cmp_level;
    logic cmp_edge;
    logic [PINS-1:0] pin_dis_comb;
    logic [MUX_W-1:0] next_mux_sel;
    logic [PINS-1:0] next_pbd;

    // ------------------------------------------------------------------
    // analog result path
    // ------------------------------------------------------------------
    // filtered or raw result, inverted when terminals are exchanged
    assign sel_out = state.ctl_two[BIT_FILTER] ? cmp_filtered_i : cmp_raw_i;
    assign presented = state.ctl_one[BIT_POWER_ON] &
        (sel_out ^ state.ctl_one[BIT_EXCHANGE]);

    cmp_sync_edge u_sync (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .async_i(presented),
        .falling_i(state.ctl_one[BIT_EDGE_POL]),
        .level_o(cmp_level),
        .edge_o(cmp_edge)
    );

    // pin disables follow the values being written, so a newly selected
    // pin is never left enabled for a cycle behind its select bits
    assign next_mux_sel = (wr_i && addr_i == ADDR_CTL_TWO) ?
        wdata_i[BIT_MUX_HI:BIT_MUX_LO] : state.ctl_two[BIT_MUX_HI:BIT_MUX_LO];
    assign next_pbd = (wr_i && addr_i == ADDR_PBD) ? wdata_i[PINS-1:0] : state.pbd;

    cmp_pin_map #(
        .PINS(PINS)
    ) u_pins (
        .mux_sel_i(next_mux_sel),
        .pbd_i(next_pbd),
        .disable_o(pin_dis_comb)
    );

    // ------------------------------------------------------------------
    // next state
    // ------------------------------------------------------------------
    always_comb begin
        logic flag;
        logic [7:0] wr_one;
        logic [7:0] rd_two;
        flag = state.ctl_one[BIT_EVT_FLAG];
        wr_one = wdata_i;
        rd_two = state.ctl_two;
        next_state = state;

        // software writes; flag bit handled with the event below
        if (wr_i) begin
            case (addr_i)
                ADDR_CTL_ONE: begin
                    next_state.ctl_one = wr_one;
                    flag = wr_one[BIT_EVT_FLAG];
                end
                ADDR_CTL_TWO: begin
                    next_state.ctl_two = {wdata_i[7:1], 1'b0};
                end
                ADDR_PBD: begin
                    next_state.pbd = wdata_i[PINS-1:0];
                end
                default: begin
                end
            endcase
        end

        if (irq_ack_i && state.irq) begin
            flag = 1'b0;
        end
        if (cmp_edge) begin
            flag = 1'b1;
        end
        next_state.ctl_one[BIT_EVT_FLAG] = flag;

        next_state.irq = flag && next_state.ctl_one[BIT_IRQ_EN] && global_irq_en_i;
        next_state.cmp_out = cmp_level;
        next_state.pin_dis = pin_dis_comb;

        // read data stands in the cycle after the strobe
        rd_two[BIT_RAW_OUT] = cmp_level;
        next_state.rdata = 8'h00;
        if (rd_i) begin
            case (addr_i)
                ADDR_CTL_ONE: next_state.rdata = state.ctl_one;
                ADDR_CTL_TWO: next_state.rdata = rd_two;
                ADDR_PBD: next_state.rdata = 8'(state.pbd);
                default: next_state.rdata = 8'h00;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // registers
    // ------------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            state <= '0;
            state.ctl_one <= RST_CTL_ONE;
            state.ctl_two <= RST_CTL_TWO;
            state.pbd <= RST_PBD;
        end else begin
            state <= next_state;
        end
    end

    // ------------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------------
    assign rdata_o = state.rdata;
    assign input_short_ctl_o = state.ctl_two[BIT_SHORT];
    assign output_filter_en_o = state.ctl_two[BIT_FILTER];
    assign ref_level_sel_o = ref_level_e'(state.ctl_one[BIT_REF_LVL_HI:BIT_REF_LVL_LO]);
    assign ref_terminal_sel_o = state.ctl_one[BIT_REF_TERM];
    assign input_exchange_o = state.ctl_one[BIT_EXCHANGE];
    assign cmp_power_on_o = state.ctl_one[BIT_POWER_ON];
    assign input_mux_sel_o = state.ctl_two[BIT_MUX_HI:BIT_MUX_LO];
    assign cmp_output_o = state.cmp_out;
    assign pin_buffer_disable_o = state.pin_dis;
    assign irq_o = state.irq;
endmodule : cmp_ctl_top

// ### tb/cmp_ctl_monitor.sv
// concurrent checks on the ports of the comparator control block
module cmp_ctl_monitor
    import cmp_ctl_pkg::*;
#(
    parameter int PINS = PIN_COUNT
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic [7:0] addr_i,
    input wire logic [7:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    input wire logic [7:0] rdata_o,
    input wire logic input_short_ctl_o,
    input wire logic output_filter_en_o,
    input wire ref_level_e ref_level_sel_o,
    input wire logic ref_terminal_sel_o,
    input wire logic input_exchange_o,
    input wire logic cmp_power_on_o,
    input wire logic [MUX_W-1:0] input_mux_sel_o,
    input wire logic cmp_output_o,
    input wire logic [PINS-1:0] pin_buffer_disable_o,
    input wire logic global_irq_en_i,
    input wire logic irq_ack_i,
    input wire logic irq_o
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!rst_n_i);
    AST_CTL_TWO_WR: assert property (wr_i && addr_i == ADDR_CTL_TWO |=>
        {input_short_ctl_o, input_mux_sel_o, output_filter_en_o} == $past(wdata_i[7:1]))
        else $error("control two write lost");
    AST_CTL_ONE_WR: assert property (wr_i && addr_i == ADDR_CTL_ONE |=>
        {input_exchange_o, ref_terminal_sel_o, ref_level_sel_o, cmp_power_on_o}
        == $past(wdata_i[7:3])) else $error("control one write lost");
    AST_PBD_WR: assert property (wr_i && addr_i == ADDR_PBD |=>
        (pin_buffer_disable_o & $past(wdata_i)) == $past(wdata_i)) else $error("pin disable");
    AST_MUX_PIN: assert property ((pin_buffer_disable_o[MUX_W-1:0] & input_mux_sel_o)
        == input_mux_sel_o) else $error("selected pin enabled");
    AST_RD_IDLE: assert property (!$past(rd_i) |-> rdata_o == 8'h00) else $error("rdata");
    AST_IRQ_GLOBAL: assert property (irq_o |-> $past(global_irq_en_i)) else $error("irq");
    AST_POWER_OFF: assert property (!cmp_power_on_o [*4] |-> !cmp_output_o)
        else $error("output high while off");
    AST_ACK_CLR: assert property (irq_o && irq_ack_i && !wr_i ##1 $stable(cmp_output_o)
        |-> !irq_o) else $error("ack did not clear");
    AST_IRQ_CAUSE: assert property ($rose(irq_o) |-> $past(wr_i)
        || ($past(global_irq_en_i) && !$past(global_irq_en_i, 2))
        || cmp_output_o != $past(cmp_output_o)) else $error("irq no cause");
    COV_IRQ: cover property ($rose(irq_o));
    COV_ACK: cover property (irq_o && irq_ack_i);
    COV_RD: cover property (rd_i && addr_i == ADDR_CTL_TWO);
endmodule : cmp_ctl_monitor

// ### tb/cmp_analog_model.sv
// behavioural analog comparator core with a slow filtered output
module cmp_analog_model (
    input wire logic clk_i,
    input int plus_i,
    input int minus_i,
    input wire logic power_i,
    input wire logic short_i,
    input wire logic exchange_i,
    output logic raw_o,
    output logic filtered_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] rc = 8'h00;
    int p;
    int m;
    assign p = exchange_i ? minus_i : plus_i;
    assign m = short_i ? p : (exchange_i ? plus_i : minus_i);
    // an unpowered core is shown high so that the block's own forcing is seen
    assign raw_o = power_i ? (p > m) : 1'b1;
    always @(posedge clk_i) rc <= {rc[6:0], raw_o};
    assign filtered_o = rc[7];
endmodule : cmp_analog_model

// ### tb/tb_cmp_ctl_top.sv
// self-checking bench for the comparator control and interrupt block
module tb_cmp_ctl_top;
    timeunit 1ns;
    timeprecision 1ps;
    import cmp_ctl_pkg::*;
    logic clk_i = 1'b0, rst_n_i = 1'b0, wr_i = 1'b0, rd_i = 1'b0, cmp_raw_i, cmp_filtered_i;
    logic global_irq_en_i = 1'b0, irq_ack_i = 1'b0, cmp_power_on_o, cmp_output_o, irq_o;
    logic input_short_ctl_o, output_filter_en_o, ref_terminal_sel_o, input_exchange_o;
    logic [7:0] addr_i = 8'h00, wdata_i = 8'h00, rdata_o, pin_buffer_disable_o, v, m;
    logic [MUX_W-1:0] input_mux_sel_o;
    ref_level_e ref_level_sel_o;
    int plus = 0, minus = 100, failures = 0, n_checks = 0;
    cmp_ctl_top u_dut (
        .clk_i(clk_i), .rst_n_i(rst_n_i), .addr_i(addr_i), .wdata_i(wdata_i),
        .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
        .cmp_raw_i(cmp_raw_i), .cmp_filtered_i(cmp_filtered_i),
        .input_short_ctl_o(input_short_ctl_o), .output_filter_en_o(output_filter_en_o),
        .ref_level_sel_o(ref_level_sel_o), .ref_terminal_sel_o(ref_terminal_sel_o),
        .input_exchange_o(input_exchange_o), .cmp_power_on_o(cmp_power_on_o),
        .input_mux_sel_o(input_mux_sel_o), .cmp_output_o(cmp_output_o),
        .pin_buffer_disable_o(pin_buffer_disable_o),
        .global_irq_en_i(global_irq_en_i), .irq_ack_i(irq_ack_i), .irq_o(irq_o)
    );
    cmp_analog_model u_model (.clk_i(clk_i), .plus_i(plus), .minus_i(minus),
        .power_i(cmp_power_on_o), .short_i(input_short_ctl_o), .exchange_i(input_exchange_o),
        .raw_o(cmp_raw_i), .filtered_o(cmp_filtered_i));
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        n_checks++;
        if (got !== exp) begin
            failures++;
            $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
        end
    endtask : check
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        addr_i <= a;
        wdata_i <= d;
        wr_i <= 1'b1;
        @(posedge clk_i);
        wr_i <= 1'b0;
        @(posedge clk_i);
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge clk_i);
        rd_i <= 1'b0;
        @(negedge clk_i);
        check(rdata_o, e);
        @(posedge clk_i);
    endtask : rd
    task automatic wait_irq(input logic lvl);
        for (int i = 0; i < 40 && irq_o !== lvl; i++) @(negedge clk_i);
        check({7'h00, irq_o}, {7'h00, lvl});
        if (irq_o !== lvl) give_verdict();
        @(posedge clk_i);
    endtask : wait_irq
    task automatic give_verdict();
        if (failures == 0 && n_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : give_verdict
    initial begin
        forever #5 clk_i = ~clk_i;
    end
    initial begin
        v = 8'($urandom(32'hfb2e4cdc));
        repeat (20) @(posedge clk_i);
        rst_n_i <= 1'b1;
        @(posedge clk_i);
        rd(ADDR_CTL_ONE, RST_CTL_ONE);
        rd(ADDR_CTL_TWO, RST_CTL_TWO);
        rd(ADDR_PBD, RST_PBD);
        for (int k = 0; k < 24; k++) begin
            v = (k == 0) ? 8'hf6 : 8'($urandom) & 8'hf6;
            m = (k == 1) ? 8'hff : 8'($urandom);
            wr(ADDR_CTL_ONE, v);
            wr(ADDR_CTL_TWO, m);
            wr(ADDR_PBD, ~v);
            wr(8'h5c, 8'hff);
            rd(8'h5c, 8'h00);
            rd(ADDR_CTL_ONE, v);
            rd(ADDR_CTL_TWO, m & 8'hfe);
            rd(ADDR_PBD, ~v);
            check({input_short_ctl_o, input_mux_sel_o, output_filter_en_o, 1'b0},
                m & 8'hfe);
            check({input_exchange_o, ref_terminal_sel_o, ref_level_sel_o,
                cmp_power_on_o, 3'h0}, v & 8'hf8);
            check(pin_buffer_disable_o, ~v | {3'h0, m[6:2]});
        end
        wr(ADDR_CTL_TWO, 8'h00);
        global_irq_en_i <= 1'b1;
        wr(ADDR_CTL_ONE, 8'h0a);
        plus <= 200;
        wait_irq(1'b1);
        rd(ADDR_CTL_ONE, 8'h0b);
        rd(ADDR_CTL_TWO, 8'h01);
        irq_ack_i <= 1'b1;
        @(posedge clk_i);
        irq_ack_i <= 1'b0;
        wait_irq(1'b0);
        wr(ADDR_CTL_ONE, 8'h0e);
        plus <= 0;
        wait_irq(1'b1);
        global_irq_en_i <= 1'b0;
        wait_irq(1'b0);
        global_irq_en_i <= 1'b1;
        wait_irq(1'b1);
        wr(ADDR_CTL_ONE, 8'h8a);
        wait_irq(1'b0);
        repeat (6) @(negedge clk_i);
        check({7'h00, cmp_output_o, irq_o}, 8'h00);
        @(posedge clk_i);
        wr(ADDR_CTL_ONE, 8'h0a);
        plus <= 200;
        // the software clear lands on the very edge that detects the rise
        repeat (2) @(posedge clk_i);
        wr(ADDR_CTL_ONE, 8'h0a);
        rd(ADDR_CTL_ONE, 8'h0b);
        wr(ADDR_CTL_ONE, 8'h0a);
        plus <= 0;
        // flush the filter history before selecting the filtered path
        repeat (10) @(posedge clk_i);
        wr(ADDR_CTL_TWO, 8'h02);
        plus <= 200;
        repeat (4) @(negedge clk_i);
        check({7'h00, cmp_output_o}, 8'h00);
        @(posedge clk_i);
        repeat (10) @(negedge clk_i);
        check({7'h00, cmp_output_o}, 8'h01);
        @(posedge clk_i);
        wr(ADDR_CTL_TWO, 8'h80);
        repeat (6) @(negedge clk_i);
        check({7'h00, cmp_output_o}, 8'h00);
        give_verdict();
    end
endmodule : tb_cmp_ctl_top
bind cmp_ctl_top cmp_ctl_monitor #(.PINS(PINS)) u_mon (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
    .input_short_ctl_o(input_short_ctl_o), .output_filter_en_o(output_filter_en_o),
    .ref_level_sel_o(ref_level_sel_o), .ref_terminal_sel_o(ref_terminal_sel_o),
    .input_exchange_o(input_exchange_o), .cmp_power_on_o(cmp_power_on_o),
    .input_mux_sel_o(input_mux_sel_o), .cmp_output_o(cmp_output_o),
    .pin_buffer_disable_o(pin_buffer_disable_o),
    .global_irq_en_i(global_irq_en_i), .irq_ack_i(irq_ack_i), .irq_o(irq_o)
);
